/* hw/rxb_pkg.sv */
// rxb_pkg: register map, field layout and carrier types of the rx bias/mask register group
package rxb_pkg;

    // ********************************
    // widths
    // ********************************
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 8;

    // ********************************
    // register offsets
    // ********************************
    localparam logic [ADDR_W-1:0] OFS_PRODUCT_IDENT_LOW = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_PRODUCT_IDENT_HIGH = 12'h005;
    localparam logic [ADDR_W-1:0] OFS_SIGNAL_CHAIN_BIAS_ENABLE = 12'h100;
    localparam logic [ADDR_W-1:0] OFS_MUTE_MASK = 12'h101;
    localparam logic [ADDR_W-1:0] OFS_POWER_ON_MASK = 12'h102;

    // ********************************
    // reset values and writable bits
    // ********************************
    localparam logic [DATA_W-1:0] RST_SIGNAL_CHAIN_BIAS_ENABLE = 8'hdf;
    localparam logic [DATA_W-1:0] RST_MUTE_MASK = 8'hbf;
    localparam logic [DATA_W-1:0] RST_POWER_ON_MASK = 8'hff;
    // bit 5 of the bias enable byte is reserved, read-only zero
    localparam logic [DATA_W-1:0] WMASK_SIGNAL_CHAIN_BIAS_ENABLE = 8'hdf;
    localparam logic [DATA_W-1:0] WMASK_MUTE_MASK = 8'hff;
    localparam logic [DATA_W-1:0] WMASK_POWER_ON_MASK = 8'hff;
    localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;

    // ********************************
    // sub-block bit positions, shared by all three control bytes
    // ********************************
    localparam int unsigned BIT_RF_CTL = 7;
    localparam int unsigned BIT_SYNTHESIZER = 6;
    localparam int unsigned BIT_RESERVED = 5;
    localparam int unsigned BIT_STEP_ATTEN = 4;
    localparam int unsigned BIT_LOWNOISE_AMP2 = 3;
    localparam int unsigned BIT_LOWNOISE_AMP1 = 2;
    localparam int unsigned BIT_LO_AMP = 1;
    localparam int unsigned BIT_IF_AMP = 0;

    // ********************************
    // carrier types
    // ********************************
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } rxb_req_t;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
    } rxb_rsp_t;

    // one bit per analog sub-block, in register bit order
    typedef struct packed {
        logic rf_ctl;
        logic synthesizer;
        logic reserved;
        logic step_atten;
        logic lownoise_amp2;
        logic lownoise_amp1;
        logic lo_amp;
        logic if_amp;
    } rxb_blocks_t;

endpackage

/* hw/rxb_sync.sv */
// rxb_sync: two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module rxb_sync #(
    parameter logic RESET_LEVEL = 1'b0
) (
    input wire logic clock, // system clock
    input wire logic srst, // synchronous reset, active high
    input wire logic clk_en, // freezes both stages while low unless srst is high
    input wire logic async_in, // level from a pin
    output logic sync_out // level in the clock domain
);

    logic meta_r;
    logic meta_nxt;
    logic sync_r;
    logic sync_nxt;

    // first stage is read only by the second stage
    always_comb begin
        meta_nxt = meta_r;
        sync_nxt = sync_r;
        if (srst) begin
            meta_nxt = RESET_LEVEL;
            sync_nxt = RESET_LEVEL;
        end else if (clk_en) begin
            meta_nxt = async_in;
            sync_nxt = meta_r;
        end
    end

    always_ff @(posedge clock) begin
        meta_r <= meta_nxt;
        sync_r <= sync_nxt;
    end

    assign sync_out = sync_r;

endmodule

/* hw/rxb_regs.sv */
// rxb_regs: product ident, bias enable, mute mask and on-mask registers of the rx chain
`timescale 1ns/1ps

// Contract
// - ident upper byte read-only at 0x005
// - ident lower byte read-only at 0x004
// - bias enable byte 0x100 resets 0xdf
// - bits 7,6 gate rf controller, synthesizer
// - bit 5 reads zero; bit 4 attenuator
// - bits 3,2 gate lna stages 2,1
// - bits 1,0 gate lo, if amplifiers
// - mute mask byte 0x101 resets 0xbf
// - bit 7 rf controller; synthesizer resets unmasked
// - bits 4..0 mask remaining sub-blocks
// - on-mask byte 0x102 resets 0xff
// - on-mask bits enable per-block on mask
module rxb_regs #(
    parameter logic [15:0] PRODUCT_IDENT = 16'h5a3c, // arbitrary value, not a real part code
    parameter int unsigned ADDR_W = rxb_pkg::ADDR_W
) (
    input wire logic clock, // 40 MHz register clock
    input wire logic srst, // synchronous reset, active high
    input wire logic clk_en, // freezes all state while low unless srst is high
    input wire rxb_pkg::rxb_req_t reg_req, // register access request
    input wire logic rx_mute, // receiver mute pin, asynchronous
    output rxb_pkg::rxb_rsp_t reg_rsp, // read answer, valid one cycle after rd
    output rxb_pkg::rxb_blocks_t bias_en_eff, // effective bias enable per sub-block
    output rxb_pkg::rxb_blocks_t power_on_msk, // on-mask byte per sub-block
    output logic mute_active // synchronised mute level
);

    // ********************************
    // elaboration checks
    // ********************************
    // offsets above 0x0ff need at least nine address bits
    if (ADDR_W != rxb_pkg::ADDR_W) begin : g_bad_addr_w
        $error("rxb_regs: ADDR_W must match the package address width");
    end

    // ********************************
    // decode helpers
    // ********************************
    function automatic logic hit(input rxb_pkg::rxb_req_t req,
                                 input logic [rxb_pkg::ADDR_W-1:0] ofs);
        hit = (req.addr == ofs);
    endfunction

    // merges writable bits of new data, keeps the rest at their fixed value
    function automatic logic [rxb_pkg::DATA_W-1:0] wmerge(
        input logic [rxb_pkg::DATA_W-1:0] old_val,
        input logic [rxb_pkg::DATA_W-1:0] new_val,
        input logic [rxb_pkg::DATA_W-1:0] wmask);
        wmerge = (new_val & wmask) | (old_val & ~wmask);
    endfunction

    // ********************************
    // mute pin crossing
    // ********************************
    // pin is asynchronous to this clock, so two flops come first
    logic mute_sync;

    rxb_sync #(
        .RESET_LEVEL(1'b0)
    ) u_mute_sync (
        .clock(clock),
        .srst(srst),
        .clk_en(clk_en),
        .async_in(rx_mute),
        .sync_out(mute_sync)
    );

    // ********************************
    // control registers
    // ********************************
    logic [rxb_pkg::DATA_W-1:0] signal_chain_bias_enable_r;
    logic [rxb_pkg::DATA_W-1:0] signal_chain_bias_enable_nxt;
    logic [rxb_pkg::DATA_W-1:0] mute_mask_r;
    logic [rxb_pkg::DATA_W-1:0] mute_mask_nxt;
    logic [rxb_pkg::DATA_W-1:0] power_on_mask_r;
    logic [rxb_pkg::DATA_W-1:0] power_on_mask_nxt;

    always_comb begin
        signal_chain_bias_enable_nxt = signal_chain_bias_enable_r;
        mute_mask_nxt = mute_mask_r;
        power_on_mask_nxt = power_on_mask_r;
        // reset acts even while clk_en is low
        if (srst) begin
            signal_chain_bias_enable_nxt = rxb_pkg::RST_SIGNAL_CHAIN_BIAS_ENABLE;
            // synthesizer bit resets clear, so mute leaves it running
            mute_mask_nxt = rxb_pkg::RST_MUTE_MASK;
            power_on_mask_nxt = rxb_pkg::RST_POWER_ON_MASK;
        end else if (clk_en && reg_req.wr) begin
            // ident bytes have no write path at all
            // a write strobe is taken on every enabled edge it stays high
            if (hit(reg_req, rxb_pkg::OFS_SIGNAL_CHAIN_BIAS_ENABLE)) begin
                // bit 5 never takes a one
                signal_chain_bias_enable_nxt = wmerge(signal_chain_bias_enable_r,
                    reg_req.wdata, rxb_pkg::WMASK_SIGNAL_CHAIN_BIAS_ENABLE);
            end
            if (hit(reg_req, rxb_pkg::OFS_MUTE_MASK)) begin
                mute_mask_nxt = wmerge(mute_mask_r, reg_req.wdata,
                    rxb_pkg::WMASK_MUTE_MASK);
            end
            if (hit(reg_req, rxb_pkg::OFS_POWER_ON_MASK)) begin
                power_on_mask_nxt = wmerge(power_on_mask_r, reg_req.wdata,
                    rxb_pkg::WMASK_POWER_ON_MASK);
            end
        end
    end

    always_ff @(posedge clock) begin
        signal_chain_bias_enable_r <= signal_chain_bias_enable_nxt;
        mute_mask_r <= mute_mask_nxt;
        power_on_mask_r <= power_on_mask_nxt;
    end

    // ********************************
    // read path
    // ********************************
    logic rsp_valid_r;
    logic rsp_valid_nxt;
    logic [rxb_pkg::DATA_W-1:0] rsp_data_r;
    logic [rxb_pkg::DATA_W-1:0] rsp_data_nxt;
    logic [rxb_pkg::DATA_W-1:0] rd_mux;
    // mux sees the registers before the edge, so a same-cycle write reads old

    always_comb begin
        rd_mux = rxb_pkg::READ_UNMAPPED;
        unique case (reg_req.addr)
            rxb_pkg::OFS_PRODUCT_IDENT_LOW: begin
                rd_mux = PRODUCT_IDENT[7:0];
            end
            rxb_pkg::OFS_PRODUCT_IDENT_HIGH: begin
                rd_mux = PRODUCT_IDENT[15:8];
            end
            rxb_pkg::OFS_SIGNAL_CHAIN_BIAS_ENABLE: begin
                rd_mux = signal_chain_bias_enable_r & rxb_pkg::WMASK_SIGNAL_CHAIN_BIAS_ENABLE;
            end
            rxb_pkg::OFS_MUTE_MASK: begin
                rd_mux = mute_mask_r;
            end
            rxb_pkg::OFS_POWER_ON_MASK: begin
                rd_mux = power_on_mask_r;
            end
            default: begin
                // unmapped offsets read as zero
                rd_mux = rxb_pkg::READ_UNMAPPED;
            end
        endcase
    end

    always_comb begin
        rsp_valid_nxt = rsp_valid_r;
        rsp_data_nxt = rsp_data_r;
        if (srst) begin
            rsp_valid_nxt = 1'b0;
            rsp_data_nxt = rxb_pkg::READ_UNMAPPED;
        end else if (clk_en) begin
            // valid lasts one enabled cycle per read strobe
            rsp_valid_nxt = reg_req.rd;
            // data holds its last value between reads
            if (reg_req.rd) begin
                rsp_data_nxt = rd_mux;
            end
        end
    end

    always_ff @(posedge clock) begin
        rsp_valid_r <= rsp_valid_nxt;
        rsp_data_r <= rsp_data_nxt;
    end

    // ********************************
    // effective bias outputs
    // ********************************
    // on-mask is only stored and copied out; it does not gate bias here
    logic [rxb_pkg::DATA_W-1:0] bias_eff_r;
    logic [rxb_pkg::DATA_W-1:0] bias_eff_nxt;
    logic [rxb_pkg::DATA_W-1:0] on_msk_r;
    logic [rxb_pkg::DATA_W-1:0] on_msk_nxt;
    logic mute_r;
    logic mute_nxt;

    always_comb begin
        bias_eff_nxt = bias_eff_r;
        on_msk_nxt = on_msk_r;
        mute_nxt = mute_r;
        if (srst) begin
            bias_eff_nxt = rxb_pkg::RST_SIGNAL_CHAIN_BIAS_ENABLE;
            on_msk_nxt = rxb_pkg::RST_POWER_ON_MASK;
            mute_nxt = 1'b0;
        end else if (clk_en) begin
            // same bit order in enable and mask bytes, so one gate per bit
            bias_eff_nxt = signal_chain_bias_enable_r
                & ~({rxb_pkg::DATA_W{mute_sync}} & mute_mask_r);
            // reserved position never carries bias
            bias_eff_nxt[rxb_pkg::BIT_RESERVED] = 1'b0;
            on_msk_nxt = power_on_mask_r;
            mute_nxt = mute_sync;
        end
    end

    always_ff @(posedge clock) begin
        bias_eff_r <= bias_eff_nxt;
        on_msk_r <= on_msk_nxt;
        mute_r <= mute_nxt;
    end

    // ********************************
    // output mapping
    // ********************************
    // every output is a register, none is decode logic
    // bit 7 rf controller, 6 synthesizer, 4 attenuator
    // bits 3..0 lna stage 2, stage 1, lo amp, if amp
    assign bias_en_eff = rxb_pkg::rxb_blocks_t'(bias_eff_r);
    assign power_on_msk = rxb_pkg::rxb_blocks_t'(on_msk_r);
    assign reg_rsp.valid = rsp_valid_r;
    assign reg_rsp.data = rsp_data_r;
    assign mute_active = mute_r;

endmodule

/* bench/rxb_regs_sva.sv */
// rxb_regs_sva: port-level assertions for the rx bias/mask register group
`timescale 1ns/1ps
module rxb_regs_sva #(
    parameter logic [15:0] PRODUCT_IDENT = 16'h5a3c
) (
    input wire logic clock, // register clock
    input wire logic srst, // sync reset
    input wire logic clk_en, // clock enable
    input wire rxb_pkg::rxb_req_t reg_req, // request
    input wire logic rx_mute, // mute pin
    input wire rxb_pkg::rxb_rsp_t reg_rsp, // read answer
    input wire rxb_pkg::rxb_blocks_t bias_en_eff, // effective bias
    input wire rxb_pkg::rxb_blocks_t power_on_msk, // on-mask copy
    input wire logic mute_active // synced mute
);
    // ********************************
    // properties
    // ********************************
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    bias_reset_a: assert property ($fell(srst) |-> bias_en_eff == 8'hdf && !reg_rsp.valid)
        else $error("bias enable reset value wrong");
    onmask_reset_a: assert property ($fell(srst) |-> power_on_msk == 8'hff)
        else $error("on-mask reset value wrong");
    reserved_off_a: assert property (!bias_en_eff.reserved)
        else $error("reserved bias bit set");
    read_pulse_a: assert property (clk_en && reg_req.rd |=> reg_rsp.valid)
        else $error("read answer missing");
    no_read_a: assert property (clk_en && !reg_req.rd |=> !reg_rsp.valid)
        else $error("answer without read");
    ident_high_a: assert property (clk_en && reg_req.rd && reg_req.addr == 12'h005
        |=> reg_rsp.data == PRODUCT_IDENT[15:8]) else $error("ident high byte wrong");
    ident_low_a: assert property (clk_en && reg_req.rd && reg_req.addr == 12'h004
        |=> reg_rsp.data == PRODUCT_IDENT[7:0]) else $error("ident low byte wrong");
    reserved_read_a: assert property (clk_en && reg_req.rd && reg_req.addr == 12'h100
        |=> !reg_rsp.data[5]) else $error("reserved bit reads one");
    mute_on_a: assert property ((clk_en && rx_mute)[*3] |=> mute_active)
        else $error("mute not taken");
    mute_off_a: assert property ((clk_en && !rx_mute)[*3] |=> !mute_active)
        else $error("mute not released");
endmodule
bind rxb_regs rxb_regs_sva #(.PRODUCT_IDENT(PRODUCT_IDENT)) i_rxb_regs_sva (.clock(clock),
    .srst(srst), .clk_en(clk_en), .reg_req(reg_req), .rx_mute(rx_mute), .reg_rsp(reg_rsp),
    .bias_en_eff(bias_en_eff), .power_on_msk(power_on_msk), .mute_active(mute_active));

/* bench/rxb_regs_tb_top.sv */
// rxb_regs_tb_top: self-checking bench for the rx bias/mask register group
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected %0t got %h exp %h", $time, g, e); end end
module rxb_regs_tb_top;
    localparam logic [15:0] ID = 16'h3c5a; // arbitrary value
    logic clock = 1'b0;
    logic srst;
    logic clk_en = 1'b1;
    logic rx_mute = 1'b0;
    rxb_pkg::rxb_req_t req = '0;
    rxb_pkg::rxb_rsp_t rsp;
    rxb_pkg::rxb_blocks_t beff;
    rxb_pkg::rxb_blocks_t pom;
    logic mact;
    logic [7:0] bias_m, mute_m, on_m;
    int fail_count = 0;
    int tests_run = 0;
    logic [31:0] seed = 32'h1dc9ffe8;
    logic [11:0] addrs [6] = '{12'h004, 12'h005, 12'h100, 12'h101, 12'h102, 12'h3a7};

    rxb_regs #(.PRODUCT_IDENT(ID), .ADDR_W(12)) i_rxb_regs (.clock(clock), .srst(srst),
        .clk_en(clk_en), .reg_req(req), .rx_mute(rx_mute), .reg_rsp(rsp),
        .bias_en_eff(beff), .power_on_msk(pom), .mute_active(mact));

    initial begin
        forever #12.5 clock = ~clock;
    end

    // ********************************
    // helpers
    // ********************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] rd_exp(input logic [11:0] a);
        case (a)
            12'h004: return ID[7:0];
            12'h005: return ID[15:8];
            12'h100: return bias_m;
            12'h101: return mute_m;
            12'h102: return on_m;
            default: return 8'h00;
        endcase
    endfunction
    // software keeps reserved bit 5 of the 0x100 and 0x101 bytes at its reset value by forcing it in the write data
    function automatic logic [7:0] keep(input logic [11:0] a, input logic [7:0] d);
        if (a == 12'h100) return d & 8'hdf;
        if (a == 12'h101) return d | 8'h20;
        return d;
    endfunction
    function automatic logic [7:0] eff_exp(input logic m);
        return bias_m & ~({8{m}} & mute_m) & 8'hdf;
    endfunction
    task automatic tick();
        @(posedge clock);
        #2;
    endtask
    // expectation taken before the write lands: same-cycle read sees the old value
    task automatic acc(input logic w, input logic r, input logic [11:0] a, input logic [7:0] d);
        logic [7:0] e;
        e = rd_exp(a);
        req = '{w, r, a, d};
        tick();
        if (w && a == 12'h100) bias_m = d & 8'hdf;
        if (w && a == 12'h101) mute_m = d;
        if (w && a == 12'h102) on_m = d;
        if (r) `CHK({rsp.valid, rsp.data}, {1'b1, e})
    endtask
    task automatic idle(input int n);
        req = '0;
        repeat (n) tick();
    endtask
    task automatic reset_all();
        srst = 1'b1;
        repeat (8) tick();
        srst = 1'b0;
        bias_m = 8'hdf;
        mute_m = 8'hbf;
        on_m = 8'hff;
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge clock);
        fail_count++;
        close_out();
    end

    // ********************************
    // scenarios
    // ********************************
    initial begin
        reset_all();
        foreach (addrs[i]) acc(1'b0, 1'b1, addrs[i], 8'h00);
        idle(1);
        `CHK({beff, pom, mact}, {8'hdf, 8'hff, 1'b0})
        $display("test reset done");
        acc(1'b1, 1'b0, 12'h100, 8'hff);
        acc(1'b1, 1'b1, 12'h101, 8'h00);
        acc(1'b1, 1'b1, 12'h005, 8'h00);
        acc(1'b0, 1'b1, 12'h100, 8'h00);
        repeat (80) begin
            logic [11:0] ra;
            seed = lfsr(seed);
            ra = addrs[seed[4:2] % 6];
            acc(seed[0], seed[1], ra, keep(ra, seed[15:8]));
        end
        idle(2);
        `CHK({beff, pom}, {eff_exp(1'b0), on_m})
        $display("test random done");
        acc(1'b1, 1'b0, 12'h100, 8'hdf);
        acc(1'b1, 1'b0, 12'h101, 8'hbf);
        rx_mute = 1'b1;
        idle(4);
        `CHK({mact, beff}, {1'b1, eff_exp(1'b1)})
        acc(1'b1, 1'b0, 12'h101, 8'h60);
        idle(2);
        `CHK(beff, eff_exp(1'b1))
        rx_mute = 1'b0;
        idle(4);
        `CHK({mact, beff}, {1'b0, eff_exp(1'b0)})
        $display("test mute done");
        clk_en = 1'b0;
        req = '{1'b1, 1'b0, 12'h101, 8'h5a};
        tick();
        clk_en = 1'b1;
        acc(1'b0, 1'b1, 12'h101, 8'h00);
        $display("test freeze done");
        idle(1);
        reset_all();
        acc(1'b0, 1'b1, 12'h101, 8'h00);
        acc(1'b0, 1'b1, 12'h100, 8'h00);
        idle(1);
        `CHK({beff, pom, mact}, {8'hdf, 8'hff, 1'b0})
        $display("test rereset done");
        close_out();
    end
endmodule
